// ==== design/scc_pkg.sv ====
package scc_pkg;

    // ****************************************
    // clocks and synthesizer arithmetic
    // ****************************************
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_KHZ = CLK_HZ / 1000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    localparam int REFERENCE_OSC_FREQUENCY_HZ = 32_000_000;
    localparam int FRAC_BITS = 19;
    // step = reference_osc_frequency / 2^19, split as (reference_osc_frequency / 2^11) / 2^8 to stay integer
    localparam int STEP_NUM = REFERENCE_OSC_FREQUENCY_HZ / 2048;
    localparam int STEP_SHIFT = FRAC_BITS - 11;
    localparam int TX_WAKE_US = 120;
    localparam int AFC_FACTOR = 5;
    localparam int PA_MIN_DBM = -18;
    localparam int PA_MAX_DBM = 13;
    localparam int PA_STEPS = PA_MAX_DBM - PA_MIN_DBM;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [6:0] ADDR_MODE = 7'h01;
    localparam logic [6:0] ADDR_FRF_MSB = 7'h07;
    localparam logic [6:0] ADDR_FRF_MID = 7'h08;
    localparam logic [6:0] ADDR_FRF_LSB = 7'h09;
    localparam logic [6:0] ADDR_PA = 7'h11;
    localparam logic [6:0] ADDR_MAP2 = 7'h26;
    localparam logic [6:0] ADDR_STATUS = 7'h27;
    localparam int SEQ_OFF_BIT = 7;
    localparam int LOCK_MAP_BIT = 4;
    localparam int ST_OSC_BIT = 7;
    localparam int ST_TXRDY_BIT = 5;
    localparam int ST_LOCK_BIT = 4;
    localparam int ST_AFC_BIT = 3;
    localparam logic [7:0] MODE_RST = 8'h01;
    localparam logic [23:0] FRF_RST = 24'h6C8000;
    localparam logic [7:0] PA_RST = 8'h1F;
    localparam logic [7:0] MAP2_RST = 8'h05;
    localparam logic [2:0] CLK_DIV_MAX = 3'h5;

    typedef enum logic [2:0] {
        MD_SLEEP = 3'h0,
        MD_STBY = 3'h1,
        MD_FS = 3'h2,
        MD_TX = 3'h3,
        MD_RX = 3'h4
    } scc_mode_t;

    typedef enum logic [3:0] {
        SQ_IDLE = 4'h1,
        SQ_OSC = 4'h2,
        SQ_PLL = 4'h4,
        SQ_RUN = 4'h8
    } scc_seq_t;

    typedef struct packed {
        logic osc_en;
        logic pll_en;
        logic rx_en;
        logic tx_en;
    } scc_ctrl_t;

endpackage

// ==== design/scc_synth_control.sv ====
`timescale 1ns/10ps
// How it works
// RL1: carrier is 24-bit word over three addresses
// RL2: upper bytes staged, low byte write applies
// RL3: step is reference frequency over 2^19
// RL4: select field routes divided reference to pin five
// RL5: clock output off in sleep, on after reset
// RL6: no clock on pin before oscillator stable
// RL7: sequencer starts PLL once oscillator stable
// RL8: sequencer starts receiver or transmitter after lock
// RL9: manual host waits oscillator time or clock
// RL10: manual host waits lock time or indicator
// RL11: lock indicator high in range, pin mappable
// RL12: lock may drop during wide deviation transmit
// RL13: coarse calibration at reset, fine per PLL start
// RL14: transmitter ready about 120 us after wake
// RL15: power steps of 1 dB, -18 to +13
// RL16: AFC settling lasts five over loop bandwidth
// RL17: host oscillator wait 500 us maximum
// RL18: host lock wait 150 us maximum
// RL19: reference oscillator is 32 MHz
// RL20: host writes upper bytes before low byte
// RL21: host disables clock output when unused
module scc_synth_control
    import scc_pkg::*;
#(
    parameter int TX_WAKE_CYCLES = TX_WAKE_US * CLK_MHZ,
    parameter int LOOP_BW_KHZ = 500
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic osc_stable,
    input wire logic pll_locked,
    input wire logic afc_start,
    output scc_ctrl_t ctrl,
    output logic cal_coarse,
    output logic cal_fine,
    output logic [23:0] synth_word,
    output logic [31:0] carrier_hz,
    output logic [4:0] pa_level,
    output logic tx_ready,
    output logic afc_busy,
    output logic lock_indicator,
    output logic general_io_four,
    output logic general_io_five
);

    localparam int AFC_CYCLES = AFC_FACTOR * CLK_KHZ / LOOP_BW_KHZ;
    // carrier of the reset word, so carrier_hz agrees with synth_word out of reset
    localparam logic [39:0] CARRIER_PROD_RST = 40'(FRF_RST) * 40'(STEP_NUM);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic sck_d;
    logic cs_n_s;
    logic sck_s;
    logic mosi_s;
    logic osc_s;
    logic lock_s;
    logic sck_rise;
    logic sck_fall;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sync1 <= 5'h01;
            sync2 <= 5'h01;
            sck_d <= 1'b0;
        end else begin
            sync1 <= {pll_locked, osc_stable, spi_mosi, spi_sck, spi_cs_n};
            sync2 <= sync1;
            sck_d <= sync2[1];
        end
    end

    assign cs_n_s = sync2[0];
    assign sck_s = sync2[1];
    assign mosi_s = sync2[2];
    assign osc_s = sync2[3];
    assign lock_s = sync2[4];
    assign sck_rise = sck_s & ~sck_d & ~cs_n_s;
    assign sck_fall = ~sck_s & sck_d & ~cs_n_s;

    // ****************************************
    // serial register port
    // ****************************************
    logic [2:0] bit_cnt;
    logic [6:0] rx_sh;
    logic first;
    logic wnr;
    logic [6:0] addr;
    logic [7:0] tx_sh;
    logic [2:0] next_bit_cnt;
    logic [6:0] next_rx_sh;
    logic next_first;
    logic next_wnr;
    logic [6:0] next_addr;
    logic [7:0] next_tx_sh;
    logic next_miso_oe;
    logic [7:0] in_byte;
    logic [6:0] rd_addr;
    logic [7:0] rd_val;
    logic wr_stb;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;

    assign in_byte = {rx_sh, mosi_s};
    // read data for the next byte is fetched as the current one completes
    assign rd_addr = first ? in_byte[6:0] : 7'(addr + 7'h01);

    always_comb begin
        next_bit_cnt = bit_cnt;
        next_rx_sh = rx_sh;
        next_first = first;
        next_wnr = wnr;
        next_addr = addr;
        next_tx_sh = tx_sh;
        next_miso_oe = ~cs_n_s;
        wr_stb = 1'b0;
        wr_addr = addr;
        wr_data = in_byte;
        if (cs_n_s) begin
            next_bit_cnt = 3'h0;
            next_first = 1'b1;
        end else if (sck_rise) begin
            next_rx_sh = in_byte[6:0];
            next_bit_cnt = 3'(bit_cnt + 3'h1);
            if (bit_cnt == 3'h7) begin
                next_tx_sh = rd_val;
                if (first) begin
                    next_first = 1'b0;
                    next_wnr = in_byte[7];
                    next_addr = in_byte[6:0];
                end else begin
                    wr_stb = wnr;
                    next_addr = rd_addr;
                end
            end
        end else if (sck_fall && bit_cnt != 3'h0) begin
            // no shift on the fall that follows a byte load
            next_tx_sh = {tx_sh[6:0], 1'b0};
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            bit_cnt <= 3'h0;
            rx_sh <= 7'h00;
            first <= 1'b1;
            wnr <= 1'b0;
            addr <= 7'h00;
            tx_sh <= 8'h00;
            spi_miso_oe <= 1'b0;
        end else begin
            bit_cnt <= next_bit_cnt;
            rx_sh <= next_rx_sh;
            first <= next_first;
            wnr <= next_wnr;
            addr <= next_addr;
            tx_sh <= next_tx_sh;
            spi_miso_oe <= next_miso_oe;
        end
    end

    assign spi_miso = tx_sh[7];

    // ****************************************
    // register file
    // ****************************************
    logic [7:0] mode_r;
    logic [7:0] frf_msb;
    logic [7:0] frf_mid;
    logic [7:0] frf_lsb;
    logic [7:0] pa_r;
    logic [7:0] map2_r;
    logic [7:0] next_mode_r;
    logic [7:0] next_frf_msb;
    logic [7:0] next_frf_mid;
    logic [7:0] next_frf_lsb;
    logic [7:0] next_pa_r;
    logic [7:0] next_map2_r;
    logic [23:0] next_synth_word;
    logic [39:0] freq_prod;
    logic [7:0] status;

    always_comb begin
        next_mode_r = mode_r;
        next_frf_msb = frf_msb;
        next_frf_mid = frf_mid;
        next_frf_lsb = frf_lsb;
        next_pa_r = pa_r;
        next_map2_r = map2_r;
        next_synth_word = synth_word;
        if (wr_stb) begin
            unique case (wr_addr)
                ADDR_MODE: next_mode_r = wr_data;
                ADDR_FRF_MSB: next_frf_msb = wr_data; // [RL1] [RL2]
                ADDR_FRF_MID: next_frf_mid = wr_data; // [RL1] [RL2]
                ADDR_FRF_LSB: begin
                    next_frf_lsb = wr_data;
                    // the whole staged word lands at once [RL2] [RL20]
                    next_synth_word = {frf_msb, frf_mid, wr_data};
                end
                ADDR_PA: next_pa_r = {3'h0, wr_data[4:0]}; // [RL15]
                ADDR_MAP2: next_map2_r = wr_data; // [RL4]
                default: ;
            endcase
        end
        // carrier = word * reference_osc_frequency / 2^19 [RL1] [RL3] [RL19]
        freq_prod = 40'(synth_word) * 40'(STEP_NUM);
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mode_r <= MODE_RST;
            frf_msb <= FRF_RST[23:16];
            frf_mid <= FRF_RST[15:8];
            frf_lsb <= FRF_RST[7:0];
            pa_r <= PA_RST;
            map2_r <= MAP2_RST; // [RL5]
            synth_word <= FRF_RST;
            carrier_hz <= CARRIER_PROD_RST[STEP_SHIFT +: 32];
        end else begin
            mode_r <= next_mode_r;
            frf_msb <= next_frf_msb;
            frf_mid <= next_frf_mid;
            frf_lsb <= next_frf_lsb;
            pa_r <= next_pa_r;
            map2_r <= next_map2_r;
            synth_word <= next_synth_word;
            carrier_hz <= freq_prod[STEP_SHIFT +: 32];
        end
    end

    // output power = -18 dBm + level, 1 dB per code [RL15]
    assign pa_level = pa_r[4:0];

    always_comb begin
        status = 8'h00;
        status[ST_OSC_BIT] = osc_s;
        status[ST_TXRDY_BIT] = tx_ready;
        status[ST_LOCK_BIT] = lock_indicator;
        status[ST_AFC_BIT] = afc_busy;
        unique case (rd_addr)
            ADDR_MODE: rd_val = mode_r;
            ADDR_FRF_MSB: rd_val = frf_msb;
            ADDR_FRF_MID: rd_val = frf_mid;
            ADDR_FRF_LSB: rd_val = frf_lsb;
            ADDR_PA: rd_val = pa_r;
            ADDR_MAP2: rd_val = map2_r;
            ADDR_STATUS: rd_val = status;
            default: rd_val = 8'h00;
        endcase
    end

    // ****************************************
    // startup sequencer
    // ****************************************
    scc_seq_t state;
    scc_seq_t next_state;
    scc_ctrl_t next_ctrl;
    logic coarse_done;
    logic next_cal_fine;
    logic [2:0] md;
    logic seq_off;
    logic need_osc;
    logic need_pll;

    assign md = mode_r[2:0];
    assign seq_off = mode_r[SEQ_OFF_BIT];
    assign need_osc = md != MD_SLEEP;
    assign need_pll = need_osc && md != MD_STBY;

    always_comb begin
        next_state = state;
        unique case (state)
            SQ_IDLE: begin
                if (need_pll) begin
                    next_state = (osc_s || seq_off) ? SQ_PLL : SQ_OSC;
                end
            end
            SQ_OSC: begin
                if (!need_pll) begin
                    next_state = SQ_IDLE;
                end else if (osc_s || seq_off) begin
                    next_state = SQ_PLL; // [RL7]
                end
            end
            SQ_PLL: begin
                if (!need_pll) begin
                    next_state = SQ_IDLE;
                end else if (lock_s || seq_off) begin
                    // manual mode leaves the waiting to the host [RL9] [RL10]
                    next_state = SQ_RUN; // [RL8]
                end
            end
            SQ_RUN: begin
                // a lock drop while modulating does not tear the path down [RL12]
                if (!need_pll) begin
                    next_state = SQ_IDLE;
                end
            end
            default: next_state = SQ_IDLE;
        endcase
        next_ctrl.osc_en = need_osc;
        next_ctrl.pll_en = next_state == SQ_PLL || next_state == SQ_RUN;
        next_ctrl.rx_en = next_state == SQ_RUN && md == MD_RX; // [RL8]
        next_ctrl.tx_en = next_state == SQ_RUN && md == MD_TX; // [RL8]
        next_cal_fine = next_ctrl.pll_en & ~ctrl.pll_en; // [RL13]
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= SQ_IDLE;
            ctrl <= '0;
            cal_fine <= 1'b0;
            cal_coarse <= 1'b0;
            coarse_done <= 1'b0;
        end else begin
            state <= next_state;
            ctrl <= next_ctrl;
            cal_fine <= next_cal_fine;
            cal_coarse <= ~coarse_done; // [RL13]
            coarse_done <= 1'b1;
        end
    end

    // ****************************************
    // timers, lock pins and clock output
    // ****************************************
    logic [15:0] tx_cnt;
    logic [15:0] afc_cnt;
    logic [5:0] div_cnt;
    logic [15:0] next_tx_cnt;
    logic [15:0] next_afc_cnt;
    logic next_tx_ready;
    logic next_afc_busy;
    logic next_gio5;
    logic [2:0] clk_sel;
    logic clk_run;

    assign clk_sel = map2_r[2:0];

    always_comb begin
        next_tx_cnt = 16'h0;
        if (ctrl.tx_en) begin
            next_tx_cnt = (tx_cnt == 16'(TX_WAKE_CYCLES)) ? tx_cnt : 16'(tx_cnt + 16'h1);
        end
        next_tx_ready = next_tx_cnt == 16'(TX_WAKE_CYCLES); // [RL14]
        next_afc_cnt = afc_cnt;
        if (afc_start && ctrl.pll_en) begin
            next_afc_cnt = 16'(AFC_CYCLES); // [RL16]
        end else if (afc_cnt != 16'h0) begin
            next_afc_cnt = 16'(afc_cnt - 16'h1);
        end
        next_afc_busy = next_afc_cnt != 16'h0;
        // held low until the crystal is stable, and in sleep [RL5] [RL6]
        clk_run = osc_s && need_osc && clk_sel <= CLK_DIV_MAX; // [RL21]
        next_gio5 = clk_run ? div_cnt[clk_sel] : 1'b0; // [RL4]
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tx_cnt <= 16'h0;
            tx_ready <= 1'b0;
            afc_cnt <= 16'h0;
            afc_busy <= 1'b0;
            div_cnt <= 6'h00;
            general_io_five <= 1'b0;
            lock_indicator <= 1'b0;
            general_io_four <= 1'b0;
        end else begin
            tx_cnt <= next_tx_cnt;
            tx_ready <= next_tx_ready;
            afc_cnt <= next_afc_cnt;
            afc_busy <= next_afc_busy;
            div_cnt <= 6'(div_cnt + 6'h01);
            general_io_five <= next_gio5;
            lock_indicator <= lock_s; // [RL11] [RL12]
            general_io_four <= lock_s & map2_r[LOCK_MAP_BIT]; // [RL11]
        end
    end

endmodule

// ==== tb/scc_synth_control_properties.sv ====
`timescale 1ns/10ps
// ****************************************
// port checker
// ****************************************
module scc_synth_control_properties
    import scc_pkg::*;
#(
    parameter int TX_WAKE_CYCLES = TX_WAKE_US * CLK_MHZ,
    parameter int LOOP_BW_KHZ = 500
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic spi_cs_n,
    input wire logic spi_miso_oe,
    input wire logic osc_stable,
    input wire logic pll_locked,
    input wire scc_ctrl_t ctrl,
    input wire logic cal_coarse,
    input wire logic cal_fine,
    input wire logic [23:0] synth_word,
    input wire logic [31:0] carrier_hz,
    input wire logic tx_ready,
    input wire logic afc_busy,
    input wire logic lock_indicator,
    input wire logic general_io_four,
    input wire logic general_io_five
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // saturating counters keep the window checks cheap
    int tx_cnt;
    int afc_cnt;
    int next_tx_cnt;
    int next_afc_cnt;
    always_comb begin
        next_tx_cnt = (ctrl.tx_en && tx_cnt < 65535) ? tx_cnt + 1 : (ctrl.tx_en ? tx_cnt : 0);
        next_afc_cnt = (afc_busy && afc_cnt < 65535) ? afc_cnt + 1 : (afc_busy ? afc_cnt : 0);
    end
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tx_cnt <= 0;
            afc_cnt <= 0;
        end else begin
            tx_cnt <= next_tx_cnt;
            afc_cnt <= next_afc_cnt;
        end
    end
    sequence s_locked;
        pll_locked [*5];
    endsequence
    sequence s_unlocked;
        !pll_locked [*5];
    endsequence
    property p_coarse_start; $fell(reset) |-> ##[0:2] cal_coarse; endproperty
    a_coarse_start: assert property (p_coarse_start) else $error("no coarse cal");
    property p_coarse_pulse; cal_coarse |=> !cal_coarse [*8]; endproperty
    a_coarse_pulse: assert property (p_coarse_pulse) else $error("coarse cal repeats");
    property p_fine; cal_fine == $rose(ctrl.pll_en); endproperty
    a_fine: assert property (p_fine) else $error("fine cal not at pll start");
    property p_run_after_pll; $rose(ctrl.rx_en || ctrl.tx_en) |-> ctrl.pll_en; endproperty
    a_run_after_pll: assert property (p_run_after_pll) else $error("path before pll");
    property p_clk_no_osc; !osc_stable [*4] |=> $stable(general_io_five); endproperty
    a_clk_no_osc: assert property (p_clk_no_osc) else $error("clock out without osc");
    property p_lock; s_locked |-> lock_indicator; endproperty
    a_lock: assert property (p_lock) else $error("lock not shown");
    property p_unlock; s_unlocked |-> !lock_indicator; endproperty
    a_unlock: assert property (p_unlock) else $error("unlock not shown");
    property p_lock_pin; general_io_four |-> lock_indicator || $past(lock_indicator); endproperty
    a_lock_pin: assert property (p_lock_pin) else $error("lock pin without lock");
    property p_tx_wait; tx_ready |-> tx_cnt >= TX_WAKE_CYCLES; endproperty
    a_tx_wait: assert property (p_tx_wait) else $error("tx ready early");
    property p_afc_len; $fell(afc_busy) |-> afc_cnt == CLK_KHZ * AFC_FACTOR / LOOP_BW_KHZ;
    endproperty
    a_afc_len: assert property (p_afc_len) else $error("afc window length");
    property p_carrier;
        carrier_hz == 32'((64'($past(synth_word)) * 64'(REFERENCE_OSC_FREQUENCY_HZ)) >> FRAC_BITS);
    endproperty
    a_carrier: assert property (p_carrier) else $error("carrier value");
    property p_word_quiet; spi_cs_n [*8] |=> $stable(synth_word); endproperty
    a_word_quiet: assert property (p_word_quiet) else $error("word changed idle");
    // select passes two sync stages and one register before the enable follows
    property p_oe_follow; spi_miso_oe == !$past(spi_cs_n, 3); endproperty
    a_oe_follow: assert property (p_oe_follow) else $error("miso enable not following select");
endmodule
bind scc_synth_control scc_synth_control_properties #(
    .TX_WAKE_CYCLES(TX_WAKE_CYCLES), .LOOP_BW_KHZ(LOOP_BW_KHZ)
) u_props (
    .core_clk(core_clk), .reset(reset), .spi_cs_n(spi_cs_n), .spi_miso_oe(spi_miso_oe),
    .osc_stable(osc_stable),
    .pll_locked(pll_locked), .ctrl(ctrl), .cal_coarse(cal_coarse), .cal_fine(cal_fine),
    .synth_word(synth_word), .carrier_hz(carrier_hz), .tx_ready(tx_ready),
    .afc_busy(afc_busy), .lock_indicator(lock_indicator),
    .general_io_four(general_io_four), .general_io_five(general_io_five)
);

// ==== tb/scc_host.sv ====
`timescale 1ns/10ps
// ****************************************
// host on the serial port and pins
// ****************************************
module scc_host (
    input wire logic core_clk,
    output logic spi_cs_n,
    output logic spi_sck,
    output logic spi_mosi,
    input wire logic spi_miso,
    input wire logic lock_indicator,
    input wire logic general_io_five
);
    initial begin
        spi_cs_n = 1'b1;
        spi_sck = 1'b0;
        spi_mosi = 1'b0;
    end
    task automatic ticks(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // five core cycles per sck phase, well above the sync limit
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            @(posedge core_clk);
            spi_sck <= 1'b0;
            spi_mosi <= tx[i];
            ticks(4);
            @(posedge core_clk);
            rx[i] = spi_miso;
            spi_sck <= 1'b1;
            ticks(4);
        end
    endtask
    task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] wd,
                          output logic [7:0] rd);
        logic [7:0] unused;
        @(posedge core_clk);
        spi_cs_n <= 1'b0;
        ticks(4);
        xfer({wr, a}, unused);
        xfer(wd, rd);
        ticks(4);
        @(posedge core_clk);
        spi_sck <= 1'b0;
        ticks(4);
        @(posedge core_clk);
        spi_cs_n <= 1'b1;
        ticks(6);
    endtask
    // bounded by the worst-case oscillator and lock times at 50 MHz
    task automatic wait_rise(input logic on_lock, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < (on_lock ? 7500 : 25000) && !seen; i++) begin
            @(posedge core_clk);
            seen = on_lock ? lock_indicator : general_io_five;
        end
    endtask
endmodule

// ==== tb/scc_synth_control_test.sv ====
`timescale 1ns/10ps
module scc_synth_control_test
    import scc_pkg::*;
;
    logic core_clk;
    logic reset;
    logic osc_stable;
    logic pll_locked;
    logic afc_start;
    logic spi_cs_n, spi_sck, spi_mosi, spi_miso, spi_miso_oe, cal_coarse, cal_fine;
    logic tx_ready, afc_busy, lock_indicator, general_io_four, general_io_five, seen;
    scc_ctrl_t ctrl;
    logic [23:0] synth_word;
    logic [31:0] carrier_hz;
    logic [4:0] pa_level;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    int n;
    always #10 core_clk = ~core_clk;
    scc_synth_control #(.TX_WAKE_CYCLES(20), .LOOP_BW_KHZ(25000)) uut (
        .core_clk(core_clk), .reset(reset), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .osc_stable(osc_stable), .pll_locked(pll_locked), .afc_start(afc_start),
        .ctrl(ctrl), .cal_coarse(cal_coarse), .cal_fine(cal_fine), .synth_word(synth_word),
        .carrier_hz(carrier_hz), .pa_level(pa_level), .tx_ready(tx_ready),
        .afc_busy(afc_busy), .lock_indicator(lock_indicator),
        .general_io_four(general_io_four), .general_io_five(general_io_five)
    );
    scc_host u_host (
        .core_clk(core_clk), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .lock_indicator(lock_indicator), .general_io_five(general_io_five)
    );
    task automatic summarize();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] unused;
        u_host.access(1'b1, a, d, unused);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_host.access(1'b0, a, 8'h00, d);
        check(32'(d), 32'(e));
    endtask
    // cycles between the 2nd and 3rd edge of the clock pin, 0 when it stays still
    task automatic half(output int h);
        logic p;
        int k;
        h = 0;
        k = 0;
        p = general_io_five;
        for (int i = 0; i < 300 && k < 3; i++) begin
            @(posedge core_clk);
            if (k == 2) h++;
            if (general_io_five !== p) k++;
            p = general_io_five;
        end
        if (k < 3) h = 0;
    endtask
    task automatic wait_ctrl(input scc_ctrl_t e);
        for (int i = 0; i < 50 && ctrl !== e; i++) @(posedge core_clk);
        check(32'(ctrl), 32'(e));
    endtask
    task automatic t_defaults();
        check(32'(synth_word), 32'(FRF_RST));
        rd(ADDR_FRF_MSB, FRF_RST[23:16]);
        rd(ADDR_FRF_MID, FRF_RST[15:8]);
        rd(ADDR_FRF_LSB, FRF_RST[7:0]);
        rd(ADDR_MAP2, MAP2_RST);
        rd(7'h30, 8'h00);
    endtask
    task automatic t_carrier();
        wr(ADDR_FRF_MSB, 8'h12);
        wr(ADDR_FRF_MID, 8'h34);
        check(32'(synth_word), 32'(FRF_RST));
        wr(ADDR_FRF_LSB, 8'h56);
        check(32'(synth_word), 32'h00123456);
        check(carrier_hz, 32'((64'h123456 * 64'(REFERENCE_OSC_FREQUENCY_HZ)) >> FRAC_BITS));
        rd(ADDR_FRF_MID, 8'h34);
        wr(ADDR_PA, 8'h00);
        check(32'(pa_level), 32'h0);
        wr(ADDR_PA, 8'h1F);
        check(32'(pa_level), 32'(PA_MAX_DBM - PA_MIN_DBM));
    endtask
    task automatic t_ref_clock_output();
        half(n);
        check(32'(n), 32'h0);
        osc_stable <= 1'b1;
        u_host.wait_rise(1'b0, seen);
        check(32'(seen), 32'h1);
        for (int s = 0; s <= 5; s++) begin
            wr(ADDR_MAP2, 8'(s));
            half(n);
            check(32'(n), 32'(1) << s);
        end
        wr(ADDR_MAP2, 8'h06);
        half(n);
        check(32'(n), 32'h0);
        wr(ADDR_MAP2, MAP2_RST);
        wr(ADDR_MODE, 8'(MD_SLEEP));
        half(n);
        check(32'(n), 32'h0);
    endtask
    task automatic t_sequence();
        osc_stable <= 1'b0;
        wr(ADDR_MODE, 8'(MD_FS));
        u_host.ticks(10);
        check(32'(ctrl), 32'h8);
        osc_stable <= 1'b1;
        wait_ctrl(4'hC);
        wr(ADDR_MODE, 8'(MD_TX));
        check(32'(ctrl), 32'hC);
        pll_locked <= 1'b1;
        u_host.wait_rise(1'b1, seen);
        check(32'(seen), 32'h1);
        wait_ctrl(4'hD);
        u_host.ticks(12);
        check(32'(tx_ready), 32'h0);
        u_host.ticks(12);
        check(32'(tx_ready), 32'h1);
        rd(ADDR_STATUS, 8'hB0);
        afc_start <= 1'b1;
        @(posedge core_clk) afc_start <= 1'b0;
        u_host.ticks(4);
        check(32'(afc_busy), 32'h1);
        u_host.ticks(12);
        check(32'(afc_busy), 32'h0);
        pll_locked <= 1'b0;
        u_host.ticks(6);
        check(32'({lock_indicator, ctrl}), 32'hD);
        pll_locked <= 1'b1;
        wr(ADDR_MAP2, MAP2_RST | 8'h10);
        check(32'(general_io_four), 32'h1);
        wr(ADDR_MODE, 8'(MD_RX));
        wait_ctrl(4'hE);
        wr(ADDR_MODE, 8'(MD_SLEEP));
        wait_ctrl(4'h0);
        // sequencer off: the path opens with neither crystal nor lock reported
        osc_stable <= 1'b0;
        pll_locked <= 1'b0;
        wr(ADDR_MODE, 8'h83);
        wait_ctrl(4'hD);
        wr(ADDR_MODE, 8'(MD_SLEEP));
        wait_ctrl(4'h0);
    endtask
    task automatic do_reset();
        reset <= 1'b1;
        u_host.ticks(20);
        reset <= 1'b0;
        u_host.ticks(4);
    endtask
    initial begin
        core_clk = 1'b0;
        reset = 1'b1;
        osc_stable = 1'b0;
        pll_locked = 1'b0;
        afc_start = 1'b0;
        do_reset();
        t_defaults();
        t_carrier();
        t_ref_clock_output();
        t_sequence();
        do_reset();
        t_defaults();
        summarize();
    end
endmodule
